// [dts_pkg.sv]
// dts_pkg: shared constants and types of the two-channel dma trigger block.
// assumes: trigger-select codes come straight from the channel mode field.
package dts_pkg;

    // ------------------------------------------------------------
    // mode control field layout
    // ------------------------------------------------------------
    localparam int unsigned MODE_W       = 8;
    localparam int unsigned TRIG_SEL_MSB = 3;
    localparam int unsigned TRIG_SEL_LSB = 0;
    localparam int unsigned TRIG_SEL_W   = TRIG_SEL_MSB - TRIG_SEL_LSB + 1;
    localparam int unsigned MODE_DIR_BIT = 5;
    localparam int unsigned EVT_W        = 16;
    localparam int unsigned NUM_CH       = 2;

    // ------------------------------------------------------------
    // trigger-select encodings
    // ------------------------------------------------------------
    localparam logic [3:0] TRIG_NONE        = 4'h0;
    localparam logic [3:0] TRIG_TMR0_CH0    = 4'h2;
    localparam logic [3:0] TRIG_TMR0_CH1    = 4'h3;
    localparam logic [3:0] TRIG_TMR0_CH4    = 4'h4;
    localparam logic [3:0] TRIG_TMR0_CH5    = 4'h5;
    localparam logic [3:0] TRIG_RADIO_TX    = 4'h6;
    localparam logic [3:0] TRIG_SER0_CH2_TX = 4'h8;
    localparam logic [3:0] TRIG_SER0_RX     = 4'h9;
    localparam logic [3:0] TRIG_LIN_TX      = 4'hA;
    localparam logic [3:0] TRIG_LIN_RX      = 4'hB;

    localparam logic [1:0] PEND_RESET = 2'h0;
    localparam logic [1:0] CH0_ONEHOT = 2'h1;
    localparam logic [1:0] CH1_ONEHOT = 2'h2;

    // ------------------------------------------------------------
    // transfer engine states, gray along idle-read-capture-write
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DTS_IDLE = 2'h0,
        DTS_RD   = 2'h1,
        DTS_CAP  = 2'h3,
        DTS_WR   = 2'h2
    } dts_state_t;

    function automatic logic dts_code_valid(input logic [3:0] code);
        dts_code_valid = (code == TRIG_NONE) || (code == TRIG_TMR0_CH0) ||
                         (code == TRIG_TMR0_CH1) || (code == TRIG_TMR0_CH4) ||
                         (code == TRIG_TMR0_CH5) || (code == TRIG_RADIO_TX) ||
                         ((code >= TRIG_SER0_CH2_TX) && (code <= TRIG_LIN_RX));
    endfunction

endpackage

// [dts_trig_if.sv]
// dts_trig_if: per-channel trigger code, event vector and start strobe.
// assumes: one instance per dma channel, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface dts_trig_if;
    logic [3:0]  code;
    logic [15:0] events;
    logic        sw_trig;
    logic        start;

    modport sel (input code, input events, input sw_trig, output start);
    modport core (output code, output events, output sw_trig, input start);
endinterface
`default_nettype wire

// [dts_trig_sel.sv]
// dts_trig_sel: turns a channel's trigger code and event vector into a start.
// assumes: events are one-cycle pulses indexed by their trigger code.
`timescale 1ns/1ps
`default_nettype none
module dts_trig_sel (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    dts_trig_if.sel   trig
);

    // ------------------------------------------------------------
    // source decode
    // ------------------------------------------------------------
    wire logic code_ok;
    wire logic hw_hit;

    assign code_ok    = dts_pkg::dts_code_valid(trig.code);
    // prohibited codes start nothing rather than a random source
    assign hw_hit     = code_ok && (trig.code != dts_pkg::TRIG_NONE) &&
                        trig.events[trig.code];
    assign trig.start = trig.sw_trig | hw_hit;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_none_ignores_hw;
        (trig.code == dts_pkg::TRIG_NONE) && !trig.sw_trig |-> !trig.start;
    endproperty
    a_none_ignores_hw: assert property (p_none_ignores_hw)
        else $error("code zero let a hardware event start the channel");

    property p_sw_always;
        trig.sw_trig |-> trig.start;
    endproperty
    a_sw_always: assert property (p_sw_always)
        else $error("software trigger did not start the channel");

endmodule
`default_nettype wire

// [dts_dma_core.sv]
// dts_dma_core: two-channel dma engine moving one unit per start between
// peripheral registers and internal ram.
// assumes: both memories answer a read strobe with data one cycle later.
//
// Overview of operation
// - a start moves one unit between peripheral register and ram, no cpu.
// - trigger select sits in bits three to zero of each mode control.
// - trigger code zero ignores hardware events; only software start works.
// - codes 2,3,4,5 pick timer unit zero channels 0,1,4,5 events.
// - code 6 picks the radio serial link transmit-complete event.
// - code 8 picks serial zero channel two transmit-complete, any mode.
// - code 9 picks the serial zero uart receive-complete event.
// - codes A and B pick lin uart transmit and receive complete.
// - two independent channels, each with its own mode control.
`timescale 1ns/1ps
`default_nettype none
module dts_dma_core #(
    parameter int unsigned SFR_AW = 8,
    parameter int unsigned RAM_AW = 12,
    parameter int unsigned DW     = 8
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire logic [dts_pkg::MODE_W-1:0] dma_mode_ctrl_ch0,
    input  wire logic [dts_pkg::MODE_W-1:0] dma_mode_ctrl_ch1,
    input  wire logic                       sw_trig_ch0,
    input  wire logic                       sw_trig_ch1,
    input  wire logic [SFR_AW-1:0]          sfr_addr_ch0,
    input  wire logic [SFR_AW-1:0]          sfr_addr_ch1,
    input  wire logic [RAM_AW-1:0]          ram_addr_ch0,
    input  wire logic [RAM_AW-1:0]          ram_addr_ch1,
    input  wire logic                       tmr0_ch0_done,
    input  wire logic                       tmr0_ch1_done,
    input  wire logic                       tmr0_ch4_done,
    input  wire logic                       tmr0_ch5_done,
    input  wire logic                       radio_ser_tx_done,
    input  wire logic                       ser0_ch2_uart_tx_done,
    input  wire logic                       ser0_ch2_clk_tx_done,
    input  wire logic                       ser0_ch2_twowire_tx_done,
    input  wire logic                       ser0_uart_rx_done,
    input  wire logic                       lin_uart_tx_done,
    input  wire logic                       lin_uart_rx_done,
    input  wire logic [DW-1:0]              sfr_rdata,
    input  wire logic [DW-1:0]              ram_rdata,
    output var  logic [SFR_AW-1:0]          sfr_addr,
    output var  logic                       sfr_rd,
    output var  logic                       sfr_wr,
    output var  logic [RAM_AW-1:0]          ram_addr,
    output var  logic                       ram_rd,
    output var  logic                       ram_wr,
    output var  logic [DW-1:0]              xfer_wdata,
    output var  logic [1:0]                 xfer_done,
    output var  logic                       busy
);

    // ------------------------------------------------------------
    // event vector, indexed by trigger code
    // ------------------------------------------------------------
    wire logic [dts_pkg::EVT_W-1:0] evt_vec;
    wire logic                      ser0_ch2_tx_any;

    // channel two of serial zero raises one shared event in every mode
    assign ser0_ch2_tx_any = ser0_ch2_uart_tx_done | ser0_ch2_clk_tx_done |
                             ser0_ch2_twowire_tx_done;
    assign evt_vec = {4'h0, lin_uart_rx_done, lin_uart_tx_done, ser0_uart_rx_done,
                      ser0_ch2_tx_any, 1'b0, radio_ser_tx_done, tmr0_ch5_done,
                      tmr0_ch4_done, tmr0_ch1_done, tmr0_ch0_done, 2'h0};

    // ------------------------------------------------------------
    // per-channel trigger selection
    // ------------------------------------------------------------
    dts_trig_if trig_ch0 ();
    dts_trig_if trig_ch1 ();

    assign trig_ch0.code    = dma_mode_ctrl_ch0[dts_pkg::TRIG_SEL_MSB:dts_pkg::TRIG_SEL_LSB];
    assign trig_ch1.code    = dma_mode_ctrl_ch1[dts_pkg::TRIG_SEL_MSB:dts_pkg::TRIG_SEL_LSB];
    assign trig_ch0.events  = evt_vec;
    assign trig_ch1.events  = evt_vec;
    assign trig_ch0.sw_trig = sw_trig_ch0;
    assign trig_ch1.sw_trig = sw_trig_ch1;

    dts_trig_sel u_sel_ch0 (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .trig    (trig_ch0.sel)
    );

    dts_trig_sel u_sel_ch1 (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .trig    (trig_ch1.sel)
    );

    // ------------------------------------------------------------
    // pending starts and arbitration
    // ------------------------------------------------------------
    // a second start while one is pending merges into it; software must
    // pace triggers no faster than one unit per four cycles across both channels
    dts_pkg::dts_state_t state_reg;
    dts_pkg::dts_state_t state_next;
    logic [1:0]          pend_reg;
    wire logic [1:0]     pend_next;
    wire logic [1:0]     start_vec;
    wire logic [1:0]     clr_vec;
    wire logic           grant;
    wire logic           grant_ch1;
    wire logic           dir_sel;

    assign start_vec = {trig_ch1.start, trig_ch0.start};
    assign grant     = (state_reg == dts_pkg::DTS_IDLE) && (pend_reg != 2'h0);
    // fixed priority to channel zero; a busy channel zero can delay channel one
    assign grant_ch1 = !pend_reg[0];
    assign clr_vec   = grant ? (grant_ch1 ? dts_pkg::CH1_ONEHOT : dts_pkg::CH0_ONEHOT)
                             : 2'h0;
    // a start in the clearing cycle survives
    assign pend_next = start_vec | (pend_reg & ~clr_vec);
    assign dir_sel   = grant_ch1 ? dma_mode_ctrl_ch1[dts_pkg::MODE_DIR_BIT]
                                 : dma_mode_ctrl_ch0[dts_pkg::MODE_DIR_BIT];

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    logic       ch_reg;
    logic       dir_reg;

    always_comb begin
        case (state_reg)
            dts_pkg::DTS_IDLE: state_next = grant ? dts_pkg::DTS_RD : dts_pkg::DTS_IDLE;
            dts_pkg::DTS_RD:   state_next = dts_pkg::DTS_CAP;
            dts_pkg::DTS_CAP:  state_next = dts_pkg::DTS_WR;
            dts_pkg::DTS_WR:   state_next = dts_pkg::DTS_IDLE;
            default:           state_next = dts_pkg::DTS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= dts_pkg::DTS_IDLE;
            pend_reg  <= dts_pkg::PEND_RESET;
            busy      <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg  <= pend_next;
            busy      <= (state_next != dts_pkg::DTS_IDLE);
        end
    end

    // dir clear: peripheral register to ram; dir set: ram to peripheral
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ch_reg   <= 1'b0;
            dir_reg  <= 1'b0;
            sfr_addr <= '0;
            ram_addr <= '0;
        end else if (grant) begin
            ch_reg   <= grant_ch1;
            dir_reg  <= dir_sel;
            sfr_addr <= grant_ch1 ? sfr_addr_ch1 : sfr_addr_ch0;
            ram_addr <= grant_ch1 ? ram_addr_ch1 : ram_addr_ch0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rd     <= 1'b0;
            ram_rd     <= 1'b0;
            sfr_wr     <= 1'b0;
            ram_wr     <= 1'b0;
            xfer_wdata <= '0;
            xfer_done  <= 2'h0;
        end else begin
            sfr_rd     <= grant && !dir_sel;
            ram_rd     <= grant && dir_sel;
            sfr_wr     <= (state_reg == dts_pkg::DTS_CAP) && dir_reg;
            ram_wr     <= (state_reg == dts_pkg::DTS_CAP) && !dir_reg;
            if (state_reg == dts_pkg::DTS_CAP) begin
                xfer_wdata <= dir_reg ? ram_rdata : sfr_rdata;
            end
            xfer_done  <= (state_reg == dts_pkg::DTS_WR) ?
                          (ch_reg ? dts_pkg::CH1_ONEHOT : dts_pkg::CH0_ONEHOT) : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    wire logic [3:0] code0;
    wire logic [3:0] code1;
    wire logic       any_rd;
    wire logic       any_wr;
    wire logic       idle_now;

    assign code0    = trig_ch0.code;
    assign code1    = trig_ch1.code;
    assign any_rd   = sfr_rd | ram_rd;
    assign any_wr   = sfr_wr | ram_wr;
    assign idle_now = (state_reg == dts_pkg::DTS_IDLE);

    sequence s_read_phase;
        any_rd && !any_wr ##1 !any_rd;
    endsequence

    sequence s_write_phase;
        any_wr ##1 (xfer_done != 2'h0) && !any_wr;
    endsequence

    property p_unit_steps;
        idle_now && (pend_reg != 2'h0) |=> s_read_phase ##1 s_write_phase;
    endproperty
    a_unit_steps: assert property (p_unit_steps)
        else $error("transfer unit did not read, write and finish in four cycles");

    property p_sfr_to_ram;
        idle_now && pend_reg[0] && !dma_mode_ctrl_ch0[dts_pkg::MODE_DIR_BIT]
            |=> sfr_rd && !ram_rd ##2 ram_wr && !sfr_wr;
    endproperty
    a_sfr_to_ram: assert property (p_sfr_to_ram)
        else $error("peripheral to ram unit used the wrong strobes");

    property p_code_zero_quiet;
        (code0 == dts_pkg::TRIG_NONE) && !sw_trig_ch0 && !pend_reg[0] |=> !pend_reg[0];
    endproperty
    a_code_zero_quiet: assert property (p_code_zero_quiet)
        else $error("channel zero became pending with code zero and no software start");

    property p_timer_pick;
        ((code0 == dts_pkg::TRIG_TMR0_CH0) && tmr0_ch0_done) ||
        ((code0 == dts_pkg::TRIG_TMR0_CH1) && tmr0_ch1_done) ||
        ((code0 == dts_pkg::TRIG_TMR0_CH4) && tmr0_ch4_done) ||
        ((code0 == dts_pkg::TRIG_TMR0_CH5) && tmr0_ch5_done) |=> pend_reg[0];
    endproperty
    a_timer_pick: assert property (p_timer_pick)
        else $error("selected timer event did not start channel zero");

    property p_radio_pick;
        (code1 == dts_pkg::TRIG_RADIO_TX) && radio_ser_tx_done |=> pend_reg[1];
    endproperty
    a_radio_pick: assert property (p_radio_pick)
        else $error("radio link transmit event did not start channel one");

    property p_ser0_ch2_pick;
        (code0 == dts_pkg::TRIG_SER0_CH2_TX) &&
        (ser0_ch2_uart_tx_done || ser0_ch2_clk_tx_done || ser0_ch2_twowire_tx_done)
            |=> pend_reg[0];
    endproperty
    a_ser0_ch2_pick: assert property (p_ser0_ch2_pick)
        else $error("serial channel two transmit event did not start channel zero");

    property p_ser0_rx_pick;
        (code1 == dts_pkg::TRIG_SER0_RX) && ser0_uart_rx_done |=> pend_reg[1];
    endproperty
    a_ser0_rx_pick: assert property (p_ser0_rx_pick)
        else $error("serial zero receive event did not start channel one");

    property p_lin_pick;
        ((code0 == dts_pkg::TRIG_LIN_TX) && lin_uart_tx_done) ||
        ((code0 == dts_pkg::TRIG_LIN_RX) && lin_uart_rx_done) |=> pend_reg[0];
    endproperty
    a_lin_pick: assert property (p_lin_pick)
        else $error("lin uart event did not start channel zero");

    property p_ch1_served;
        idle_now && (pend_reg == dts_pkg::CH1_ONEHOT) |-> ##4 (xfer_done == dts_pkg::CH1_ONEHOT);
    endproperty
    a_ch1_served: assert property (p_ch1_served)
        else $error("channel one unit did not finish on its own done bit");

    property p_done_single;
        // a unit granted in the finish cycle raises busy again straight after
        (xfer_done != 2'h0) |=> (xfer_done == 2'h0) && (busy == $past(grant));
    endproperty
    a_done_single: assert property (p_done_single)
        else $error("unit finish lasted more than one cycle");

endmodule
`default_nettype wire

// [dts_mem_model.sv]
// dts_mem_model: peripheral register file and internal ram facing the dma core.
// assumes: read strobes answered one cycle later; writes are logged for the bench.
`timescale 1ns/1ps
`default_nettype none
module dts_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_wr,
    input  wire logic [11:0] ram_addr,
    input  wire logic        ram_rd,
    input  wire logic        ram_wr,
    input  wire logic [7:0]  xfer_wdata,
    output var  logic [7:0]  sfr_rdata,
    output var  logic [7:0]  ram_rdata,
    output var  logic [15:0] w_cnt,
    output var  logic        w_sfr,
    output var  logic [11:0] w_addr,
    output var  logic [7:0]  w_data
);
    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    initial begin
        sfr_rdata = 8'h00;
        ram_rdata = 8'h00;
        w_cnt     = 16'h0000;
        w_sfr     = 1'b0;
        w_addr    = 12'h000;
        w_data    = 8'h00;
    end

    // contents follow the address; between answers data toggles so stale reads show
    always @(posedge clk_sys) begin
        sfr_rdata <= sfr_rd ? (sfr_addr ^ 8'h5A) : ~sfr_rdata;
        ram_rdata <= ram_rd ? (ram_addr[7:0] ^ {ram_addr[11:8], 4'hC}) : ~ram_rdata;
    end

    // ------------------------------------------------------------
    // write log
    // ------------------------------------------------------------
    // both strobes at once count twice, so a double write is visible
    always @(posedge clk_sys) begin
        if (sfr_wr || ram_wr) begin
            w_cnt  <= w_cnt + {15'h0000, sfr_wr} + {15'h0000, ram_wr};
            w_sfr  <= sfr_wr;
            w_addr <= sfr_wr ? {4'h0, sfr_addr} : ram_addr;
            w_data <= xfer_wdata;
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
// tb: self-checking bench for the two-channel dma trigger core.
// assumes: dts_mem_model answers the memory ports; all inputs driven 1 ns after clk.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  mode0, mode1, sfr_a0, sfr_a1, sfr_rdata, ram_rdata, xfer_wdata, sfr_addr;
    logic [11:0] ram_a0, ram_a1, ram_addr, w_addr;
    logic [7:0]  w_data;
    logic        sw0, sw1, sfr_rd, sfr_wr, ram_rd, ram_wr, busy, w_sfr;
    logic [10:0] ev;
    logic [1:0]  xfer_done;
    logic [15:0] w_cnt;
    integer      seed;
    int          n_fail, num_checks, n_done0, n_done1, i, ch;
    time         t_done0, t_done1;
    logic [3:0]  c;
    // event order of ev: timer 0/1/4/5, radio tx, ch2 uart/clk/twowire tx, rx, lin tx/rx
    localparam logic [3:0] EV_CODE [11] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h8, 4'h8,
                                            4'h9, 4'hA, 4'hB};

    dts_dma_core #(.SFR_AW(8), .RAM_AW(12), .DW(8)) u_dts_dma_core (
        .clk_sys(clk_sys), .rst_b(rst_b), .dma_mode_ctrl_ch0(mode0), .dma_mode_ctrl_ch1(mode1),
        .sw_trig_ch0(sw0), .sw_trig_ch1(sw1), .sfr_addr_ch0(sfr_a0), .sfr_addr_ch1(sfr_a1),
        .ram_addr_ch0(ram_a0), .ram_addr_ch1(ram_a1), .tmr0_ch0_done(ev[0]),
        .tmr0_ch1_done(ev[1]), .tmr0_ch4_done(ev[2]), .tmr0_ch5_done(ev[3]),
        .radio_ser_tx_done(ev[4]), .ser0_ch2_uart_tx_done(ev[5]),
        .ser0_ch2_clk_tx_done(ev[6]), .ser0_ch2_twowire_tx_done(ev[7]),
        .ser0_uart_rx_done(ev[8]), .lin_uart_tx_done(ev[9]), .lin_uart_rx_done(ev[10]),
        .sfr_rdata(sfr_rdata), .ram_rdata(ram_rdata), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
        .xfer_wdata(xfer_wdata), .xfer_done(xfer_done), .busy(busy));

    dts_mem_model u_dts_mem_model (
        .clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .xfer_wdata(xfer_wdata),
        .sfr_rdata(sfr_rdata), .ram_rdata(ram_rdata), .w_cnt(w_cnt), .w_sfr(w_sfr),
        .w_addr(w_addr), .w_data(w_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [10:0] ev_mask(input logic [3:0] code);
        for (int j = 0; j < 11; j++) begin
            ev_mask[j] = (EV_CODE[j] == code);
        end
    endfunction

    function automatic logic [15:0] exp_data(input logic dir, input logic [7:0] sa,
                                             input logic [11:0] ra);
        exp_data = dir ? {8'h00, ra[7:0] ^ {ra[11:8], 4'hC}} : {8'h00, sa ^ 8'h5A};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic settle;
        int k;
        tick(8);
        for (k = 0; k < 20 && busy !== 1'b0; k++) tick(1);
        if (k == 20) begin
            $display("MISMATCH busy expected 0 seen %b", busy);
            n_fail++;
            wrap_up;
        end
    endtask

    // one channel armed with code, the other at code zero; pulse then count units
    task automatic go(input int chn, input logic [3:0] code, input logic [10:0] hw,
                      input logic swp, input int exp_n);
        logic [7:0]  m;
        logic [7:0]  sa;
        logic [11:0] ra;
        int          d0, d1;
        logic [15:0] wc;
        m = 8'($random(seed));
        sa = 8'($random(seed));
        ra = 12'($random(seed));
        if (chn == 0) begin
            mode0 = {m[7:4], code};
            mode1 = {m[3:0], 4'h0};
            sfr_a0 = sa;
            ram_a0 = ra;
        end else begin
            mode1 = {m[7:4], code};
            mode0 = {m[3:0], 4'h0};
            sfr_a1 = sa;
            ram_a1 = ra;
        end
        tick(1);
        d0 = n_done0;
        d1 = n_done1;
        wc = w_cnt;
        ev = hw;
        sw0 = swp && (chn == 0);
        sw1 = swp && (chn == 1);
        tick(1);
        ev = 11'h000;
        sw0 = 1'b0;
        sw1 = 1'b0;
        settle();
        chk("units ch0", (chn == 0) ? 16'(exp_n) : 16'h0000, 16'(n_done0 - d0));
        chk("units ch1", (chn == 1) ? 16'(exp_n) : 16'h0000, 16'(n_done1 - d1));
        chk("writes", 16'(exp_n), w_cnt - wc);
        if (exp_n == 1) begin
            chk("write to sfr", {15'h0000, m[5]}, {15'h0000, w_sfr});
            chk("write addr", m[5] ? {8'h00, sa} : {4'h0, ra}, {4'h0, w_addr});
            chk("write data", exp_data(m[5], sa, ra), {8'h00, w_data});
        end
    endtask

    // ------------------------------------------------------------
    // clock, unit counters, main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (xfer_done[0] === 1'b1) begin n_done0++; t_done0 = $time; end
        if (xfer_done[1] === 1'b1) begin n_done1++; t_done1 = $time; end
    end

    initial begin
        seed = 32'h8E916CA0;
        {rst_b, sw0, sw1, ev} = 14'h0000;
        {mode0, mode1, sfr_a0, sfr_a1} = 32'h00000000;
        {ram_a0, ram_a1} = 24'h000000;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        chk("done after reset", 16'h0000, {14'h0000, xfer_done});
        for (ch = 0; ch < 2; ch++) begin
            go(ch, 4'h0, 11'h7FF, 1'b0, 0);
            go(ch, 4'h7, 11'h7FF, 1'b0, 0);
            go(ch, 4'hC, 11'h7FF, 1'b0, 0);
            go(ch, 4'h0, 11'h000, 1'b1, 1);
        end
        // every listed source, with all foreign sources pulsed first
        for (i = 0; i < 11; i++) begin
            c = EV_CODE[i];
            ch = $random(seed) & 1;
            go(ch, c, ~ev_mask(c), 1'b0, 0);
            go(ch, c, 11'h001 << i, 1'b0, 1);
        end
        repeat (24) begin
            i = {$random(seed)} % 11;
            ch = $random(seed) & 1;
            go(ch, EV_CODE[i], 11'h001 << i, 1'($random(seed)), 1);
        end
        // simultaneous software starts on both channels
        mode0 = 8'h00;
        mode1 = 8'h20;
        ch = n_done0;
        i = n_done1;
        c = w_cnt[3:0];
        sw0 = 1'b1;
        sw1 = 1'b1;
        tick(1);
        sw0 = 1'b0;
        sw1 = 1'b0;
        settle();
        tick(8);
        chk("both units", 16'h0101, {8'(n_done0 - ch), 8'(n_done1 - i)});
        chk("both writes", 16'h0002, {12'h000, w_cnt[3:0] - c});
        chk("ch0 first", 16'h0001, {15'h0000, t_done0 < t_done1});
        wrap_up;
    end
endmodule
`default_nettype wire
